// ---- pkg/cspt_map.svh ----
`ifndef CSPT_MAP_SVH
`define CSPT_MAP_SVH
// ==========================================================================
// word and frame geometry
`define CSPT_WORD_BITS      16
`define CSPT_LAST_BIT       4'hf
`define CSPT_ADDR_BITS_END  4'h8
`define CSPT_LAST_SLOT      3'h7
`define CSPT_SLOT_LO        3'h2
`define CSPT_SLOT_HI        3'h5
// ==========================================================================
// hardwired multiprocessor addresses
`define CSPT_TXA_LO         8'h04
`define CSPT_TXA_HI         8'h20
`define CSPT_RXD_LO         8'h08
`define CSPT_RXD_HI         8'h40
`define CSPT_RXC_LO         8'h10
`define CSPT_RXC_HI         8'h80
`define CSPT_PROTOCOL       8'h00
// ==========================================================================
// control word fields and reset values
`define CSPT_SEL_MSB        15
`define CSPT_SEL_LSB        14
`define CSPT_RUN_BIT        12
`define CSPT_CTRL0_RESET    16'h0010
`define CSPT_CTRL1_RESET    16'h4030
`define CSPT_CTRL2_RESET    16'h8000
`define CSPT_CTRL3_RESET    16'hc000
// ==========================================================================
// control-load strobe period, in serial bit clocks minus one
`define CSPT_IDLE_DIV_LAST  4'hf
`endif

// ---- pkg/cspt_pkg.sv ----
package cspt_pkg;
	// ======================================================================
	// port configuration
	typedef enum logic [2:0] {
		CSPT_MODE_PASSIVE = 3'b001,
		CSPT_MODE_ACTIVE  = 3'b010,
		CSPT_MODE_TDM     = 3'b100
	} cspt_mode_type;
	// ======================================================================
	// link sequencer
	typedef enum logic [2:0] {
		CSPT_ST_IDLE = 3'b001,
		CSPT_ST_XFER = 3'b010,
		CSPT_ST_TDM  = 3'b100
	} cspt_state_type;
endpackage : cspt_pkg

// ---- rtl/cspt_serial_port.sv ----
`timescale 1ns/1ps
`include "cspt_map.svh"

module cspt_serial_port (
	input  wire logic        i_clock,
	input  wire logic        i_reset_n,
	input  wire logic        i_serial_bit_clock,
	input  wire logic        i_bus_frame_line,
	output logic             o_bus_frame_line,
	output logic             o_bus_frame_line_oe,
	input  wire logic        i_serial_data_in,
	output logic             o_serial_data_out,
	output logic             o_serial_data_out_oe,
	input  wire logic        i_serial_address_line,
	output logic             o_serial_address_line,
	output logic             o_serial_address_line_oe,
	input  wire logic        i_slot_select_pin,
	input  wire logic        i_mode_class_pin,
	input  wire logic        i_sample_tick,
	input  wire logic [15:0] i_capture_word,
	output logic [15:0]      o_playback_word,
	output logic             o_playback_full,
	output logic             o_status_flag,
	output logic             o_ctrl_write,
	output logic [15:0]      o_ctrl_reg0,
	output logic [15:0]      o_ctrl_reg1,
	output logic [15:0]      o_ctrl_reg2,
	output logic [15:0]      o_ctrl_reg3
);
	// ======================================================================
	// helpers
	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] b);
		addr_hit = |(a & b);
	endfunction : addr_hit
	function automatic logic [7:0] pick8(input logic sel, input logic [7:0] lo,
		input logic [7:0] hi);
		pick8 = sel ? hi : lo;
	endfunction : pick8

	// ======================================================================
	// reset release and input synchronisers
	logic rst_s1_r;
	logic rst_n_r;
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	logic [5:0] pin_s1_r;
	logic [5:0] pin_s2_r;
	logic       bclk_d_r;
	always_ff @(posedge i_clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pin_s1_r <= 6'h0b;
			pin_s2_r <= 6'h0b;
			bclk_d_r <= 1'b1;
		end else begin
			pin_s1_r <= {i_mode_class_pin, i_slot_select_pin, i_serial_address_line,
				i_serial_data_in, i_bus_frame_line, i_serial_bit_clock};
			pin_s2_r <= pin_s1_r;
			bclk_d_r <= pin_s2_r[0];
		end
	end

	wire bclk     = pin_s2_r[0];
	wire sync_in  = pin_s2_r[1];
	wire din      = pin_s2_r[2];
	wire addr_in  = pin_s2_r[3];
	wire slot_sel = pin_s2_r[4];
	wire mclass   = pin_s2_r[5];
	wire rise     = bclk & ~bclk_d_r;
	wire fall     = ~bclk & bclk_d_r;
	// ======================================================================
	// state
	cspt_pkg::cspt_state_type state_r;
	cspt_pkg::cspt_state_type state_nxt;
	logic [3:0]  bit_cnt_r;
	logic [3:0]  bit_cnt_nxt;
	logic [2:0]  slot_r;
	logic [2:0]  slot_nxt;
	logic [15:0] isr_r;
	logic [15:0] osr_r;
	logic [15:0] osr_nxt;
	logic [15:0] adr_sr_r;
	logic [15:0] adr_sr_nxt;
	logic [7:0]  rxa_r;
	logic        addr_low_r;
	logic        show_status_r;
	logic        show_status_nxt;
	logic        shift_due_r;
	logic        drive_en_r;
	logic        drive_en_nxt;
	logic [15:0] cap_word_r;
	logic        cap_full_r;
	logic [15:0] play_word_r;
	logic        play_full_r;
	logic        status_r;
	logic [15:0] ctrl_r [4];
	logic        ctrl_wr_r;
	logic        strobe_r;
	logic        pend_r;
	logic [3:0]  div_cnt_r;
	logic        prev_frame_r;

	// ======================================================================
	// mode and address decode
	cspt_pkg::cspt_mode_type mode;
	assign mode = mclass ? cspt_pkg::CSPT_MODE_TDM :
		(slot_sel ? cspt_pkg::CSPT_MODE_ACTIVE :
		cspt_pkg::CSPT_MODE_PASSIVE);
	wire is_tdm    = (mode == cspt_pkg::CSPT_MODE_TDM);
	wire is_active = (mode == cspt_pkg::CSPT_MODE_ACTIVE);
	wire run_bit   = ctrl_r[0][`CSPT_RUN_BIT];
	wire [7:0] tx_addr  = pick8(slot_sel, `CSPT_TXA_LO, `CSPT_TXA_HI);
	wire [7:0] rxd_addr = pick8(slot_sel, `CSPT_RXD_LO, `CSPT_RXD_HI);
	wire [7:0] rxc_addr = pick8(slot_sel, `CSPT_RXC_LO, `CSPT_RXC_HI);
	wire [2:0] own_slot = slot_sel ? `CSPT_SLOT_HI : `CSPT_SLOT_LO;
	// frame strobe as seen on rising edges; own strobe in active mode
	wire frame_now  = is_active ? strobe_r : sync_in;
	wire frame_fall = rise & prev_frame_r & ~frame_now;
	wire busy       = (state_r != cspt_pkg::CSPT_ST_IDLE);
	wire sample_bit = rise & busy & ~frame_fall;
	wire done       = sample_bit & (bit_cnt_r == `CSPT_LAST_BIT);
	wire [15:0] word_in = {isr_r[14:0], din};
	// address low on the current bit counts only inside the first 15 bits
	wire addr_low_eff = addr_low_r | (~addr_in & (bit_cnt_r != `CSPT_LAST_BIT));
	wire xfer_done = done & (state_r == cspt_pkg::CSPT_ST_XFER);
	wire tdm_done  = done & (state_r == cspt_pkg::CSPT_ST_TDM);
	wire data_hit  = addr_hit(rxa_r, rxd_addr);
	wire ctrl_hit  = addr_hit(rxa_r, rxc_addr);
	wire play_take = (xfer_done & ~addr_low_eff) | (tdm_done & data_hit);
	wire ctrl_take = (xfer_done & addr_low_eff) |
		(tdm_done & ~data_hit & ctrl_hit);
	wire next_own = tdm_done & (slot_r != `CSPT_LAST_SLOT) &
		((slot_r + 3'h1) == own_slot);
	wire start_pa = frame_fall & ~is_tdm;
	wire start_td = frame_fall & is_tdm;
	wire load_osr = start_pa | next_own;
	wire cap_take = load_osr & cap_full_r;

	// ======================================================================
	// link sequencer
	always_comb begin
		state_nxt       = state_r;
		bit_cnt_nxt     = bit_cnt_r;
		slot_nxt        = slot_r;
		osr_nxt         = osr_r;
		adr_sr_nxt      = adr_sr_r;
		show_status_nxt = show_status_r;
		drive_en_nxt    = drive_en_r;
		if (fall && shift_due_r) begin
			osr_nxt    = {osr_r[14:0], 1'b0};
			adr_sr_nxt = {1'b1, adr_sr_r[15:1]};
		end
		case (state_r)
			cspt_pkg::CSPT_ST_IDLE: begin
				if (rise && !addr_in && !is_tdm) begin
					show_status_nxt = 1'b1;
				end
			end
			cspt_pkg::CSPT_ST_XFER: begin
				if (sample_bit && !addr_in && bit_cnt_r != `CSPT_LAST_BIT) begin
					show_status_nxt = 1'b1;
				end
				if (done) begin
					state_nxt = cspt_pkg::CSPT_ST_IDLE;
				end else if (sample_bit) begin
					bit_cnt_nxt = bit_cnt_r + 4'h1;
				end
			end
			cspt_pkg::CSPT_ST_TDM: begin
				if (done) begin
					bit_cnt_nxt  = 4'h0;
					slot_nxt     = slot_r + 3'h1;
					drive_en_nxt = next_own;
					if (slot_r == `CSPT_LAST_SLOT) begin
						state_nxt = cspt_pkg::CSPT_ST_IDLE;
					end
				end else if (sample_bit) begin
					bit_cnt_nxt = bit_cnt_r + 4'h1;
				end
			end
			default: begin
				state_nxt = cspt_pkg::CSPT_ST_IDLE;
			end
		endcase
		if (start_pa) begin
			state_nxt       = cspt_pkg::CSPT_ST_XFER;
			bit_cnt_nxt     = 4'h0;
			show_status_nxt = 1'b0;
			osr_nxt         = cap_full_r ? cap_word_r : 16'h0000;
		end else if (start_td) begin
			state_nxt    = cspt_pkg::CSPT_ST_TDM;
			bit_cnt_nxt  = 4'h0;
			slot_nxt     = 3'h0;
			drive_en_nxt = 1'b0;
		end else if (next_own) begin
			osr_nxt    = cap_full_r ? cap_word_r : 16'h0000;
			adr_sr_nxt = cap_full_r ? {~`CSPT_PROTOCOL, ~tx_addr} :
				16'hffff;
		end
	end
	always_ff @(posedge i_clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			state_r       <= cspt_pkg::CSPT_ST_IDLE;
			bit_cnt_r     <= 4'h0;
			slot_r        <= 3'h0;
			osr_r         <= 16'h0000;
			adr_sr_r      <= 16'hffff;
			show_status_r <= 1'b0;
			drive_en_r    <= 1'b0;
		end else begin
			state_r       <= state_nxt;
			bit_cnt_r     <= bit_cnt_nxt;
			slot_r        <= slot_nxt;
			osr_r         <= osr_nxt;
			adr_sr_r      <= adr_sr_nxt;
			show_status_r <= show_status_nxt;
			drive_en_r    <= drive_en_nxt;
		end
	end

	// ======================================================================
	// receive shifters
	always_ff @(posedge i_clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			isr_r        <= 16'h0000;
			rxa_r        <= 8'h00;
			addr_low_r   <= 1'b0;
			shift_due_r  <= 1'b0;
			prev_frame_r <= 1'b1;
		end else begin
			if (rise) begin
				prev_frame_r <= frame_now;
			end
			if (frame_fall) begin
				addr_low_r  <= 1'b0;
				shift_due_r <= 1'b0;
			end else if (sample_bit) begin
				isr_r       <= word_in;
				addr_low_r  <= (bit_cnt_r == `CSPT_LAST_BIT) ? 1'b0 : addr_low_eff;
				shift_due_r <= (bit_cnt_r != `CSPT_LAST_BIT);
				if (bit_cnt_r < `CSPT_ADDR_BITS_END) begin
					rxa_r <= {~addr_in, rxa_r[7:1]};
				end
			end else if (fall) begin
				shift_due_r <= 1'b0;
			end
		end
	end

	// ======================================================================
	// buffers, status flag and control registers
	always_ff @(posedge i_clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			cap_word_r  <= 16'h0000;
			cap_full_r  <= 1'b0;
			play_word_r <= 16'h0000;
			play_full_r <= 1'b0;
			status_r    <= 1'b0;
			ctrl_wr_r   <= 1'b0;
			ctrl_r[0]   <= `CSPT_CTRL0_RESET;
			ctrl_r[1]   <= `CSPT_CTRL1_RESET;
			ctrl_r[2]   <= `CSPT_CTRL2_RESET;
			ctrl_r[3]   <= `CSPT_CTRL3_RESET;
		end else begin
			// codec event wins over a same-cycle clear
			if (i_sample_tick) begin
				cap_word_r <= i_capture_word;
				cap_full_r <= 1'b1;
				status_r   <= 1'b1;
			end else begin
				cap_full_r <= cap_full_r & ~cap_take;
				status_r   <= status_r & ~(cap_take | play_take);
			end
			if (play_take) begin
				play_word_r <= word_in;
				play_full_r <= 1'b1;
			end else if (i_sample_tick) begin
				play_full_r <= 1'b0;
			end
			ctrl_wr_r <= ctrl_take;
			if (ctrl_take) begin
				ctrl_r[word_in[`CSPT_SEL_MSB:`CSPT_SEL_LSB]] <= word_in;
			end
		end
	end

	// ======================================================================
	// active-mode strobe generator, changes on falling bit clock
	always_ff @(posedge i_clock or negedge rst_n_r) begin
		if (!rst_n_r) begin
			strobe_r  <= 1'b1;
			pend_r    <= 1'b0;
			div_cnt_r <= 4'h0;
		end else begin
			if (i_sample_tick) begin
				pend_r <= 1'b1;
			end else if (fall) begin
				pend_r <= 1'b0;
			end
			if (fall) begin
				div_cnt_r <= div_cnt_r + 4'h1;
				if (!is_active) begin
					strobe_r <= 1'b1;
				end else if (run_bit) begin
					strobe_r <= ~pend_r;
				end else begin
					strobe_r <= (div_cnt_r != `CSPT_IDLE_DIV_LAST);
				end
			end
		end
	end

	// ======================================================================
	// outputs
	assign o_bus_frame_line         = strobe_r;
	assign o_bus_frame_line_oe      = is_active;
	assign o_serial_data_out        = (show_status_r & ~is_tdm) ? status_r : osr_r[15];
	assign o_serial_data_out_oe     = is_tdm ? drive_en_r : 1'b1;
	assign o_serial_address_line    = adr_sr_r[0];
	assign o_serial_address_line_oe = is_tdm & drive_en_r;
	assign o_playback_word          = play_word_r;
	assign o_playback_full          = play_full_r;
	assign o_status_flag            = status_r;
	assign o_ctrl_write             = ctrl_wr_r;
	assign o_ctrl_reg0              = ctrl_r[0];
	assign o_ctrl_reg1              = ctrl_r[1];
	assign o_ctrl_reg2              = ctrl_r[2];
	assign o_ctrl_reg3              = ctrl_r[3];

	// ======================================================================
	// checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!rst_n_r);
	sequence s_pa_start;
		start_pa && cap_full_r && !i_sample_tick;
	endsequence
	sequence s_word_end;
		xfer_done && !addr_low_eff;
	endsequence
	status_set_a: assert property (i_sample_tick |=> status_r)
		else $error("status flag not set by sample event");
	status_clr_a: assert property (s_pa_start |=> !status_r && !cap_full_r)
		else $error("status flag not cleared by capture transfer");
	osr_load_a: assert property (s_pa_start |=> osr_r == $past(cap_word_r))
		else $error("output shifter not loaded from capture buffer");
	play_load_a: assert property (s_word_end |=> play_full_r && play_word_r == $past(word_in))
		else $error("playback buffer not loaded at word end");
	ctrl_pulse_a: assert property (ctrl_take |=> o_ctrl_write ##1 !o_ctrl_write)
		else $error("control write pulse wrong");
	ctrl_sel_a: assert property (ctrl_take && word_in[15:14] == 2'h2 |=> o_ctrl_reg2 == $past(word_in))
		else $error("control word landed in wrong register");
	slot_drive_a: assert property (o_serial_address_line_oe |-> slot_r == own_slot)
		else $error("bus driven outside own slot");
	empty_slot_a: assert property (next_own && !cap_full_r |=> osr_r == 16'h0000 && adr_sr_r == 16'hffff)
		else $error("empty slot not sent as zeros and ones");
	idle_strobe_a: assert property (fall && is_active && !run_bit && div_cnt_r == 4'hf |=> !strobe_r)
		else $error("idle strobe missing after 16 bit clocks");
	status_show_a: assert property (!busy && rise && !addr_in && !is_tdm && !frame_fall |=> show_status_r)
		else $error("status not shown after low address");
	run_strobe_a: assert property (fall && is_active && run_bit && pend_r |=> !strobe_r)
		else $error("run strobe missing after sample event");
endmodule : cspt_serial_port

// ---- tb/cspt_host_model.sv ----
`timescale 1ns/1ps

// ==========================================================================
// host serial port: bit clock, frame strobe, data and address lines
module cspt_host_model (
	output logic      o_serial_bit_clock,
	output logic      o_bus_frame_line,
	output logic      o_serial_data_in,
	output logic      o_serial_address_line,
	input  wire logic i_data_bus,
	input  wire logic i_address_bus,
	input  wire logic i_dev_oe
);
	// mode class pin has no port here; the test drives it, high for the tdm frames
	initial begin
		o_serial_bit_clock    = 1'b0;
		o_bus_frame_line      = 1'b1;
		o_serial_data_in      = 1'b0;
		o_serial_address_line = 1'b1;
		forever #40 o_serial_bit_clock = ~o_serial_bit_clock;
	end

	// one passive transfer or one whole tdm frame of n_slots slots
	task automatic frame_xfer(
		input  int          n_slots,
		input  logic [15:0] tx [8],
		input  logic [15:0] ad [8],
		output logic [15:0] rx [8],
		output logic [15:0] rxa [8],
		output int          own_bits
	);
		own_bits = 0;
		@(negedge o_serial_bit_clock);
		o_bus_frame_line <= 1'b0;
		for (int s = 0; s < n_slots; s++) begin
			for (int i = 0; i < 16; i++) begin
				@(negedge o_serial_bit_clock);
				o_bus_frame_line      <= 1'b1;
				o_serial_data_in      <= tx[s][15 - i];
				o_serial_address_line <= ad[s][i];
				@(posedge o_serial_bit_clock);
				rx[s][15 - i] = i_data_bus;
				rxa[s][i]     = i_address_bus;
				if (i_dev_oe === 1'b1)
					own_bits++;
			end
		end
		@(negedge o_serial_bit_clock);
		// released data line shows the inverse of its last bit
		o_serial_data_in      <= ~o_serial_data_in;
		o_serial_address_line <= 1'b1;
		repeat (3) @(negedge o_serial_bit_clock);
	endtask : frame_xfer

	task automatic addr_pulse;
		@(negedge o_serial_bit_clock);
		o_serial_address_line <= 1'b0;
		repeat (2) @(negedge o_serial_bit_clock);
		o_serial_address_line <= 1'b1;
	endtask : addr_pulse
endmodule : cspt_host_model

// ---- tb/cspt_serial_port_test.sv ----
`timescale 1ns/1ps
`include "cspt_map.svh"

module cspt_serial_port_test;
	logic        clock;
	logic        reset_n;
	logic        slot_sel;
	logic        mode_cls;
	logic        tick;
	logic [15:0] cap;
	logic [15:0] tx [8];
	logic [15:0] ad [8];
	logic [15:0] rx [8];
	logic [15:0] rxa [8];
	int          nb;
	int          c1;
	int          c2;
	int          own;
	int          err_count;
	int          n_compared;
	wire         bclk;
	wire         h_frame;
	wire         h_data;
	wire         h_addr;
	wire         d_frame;
	wire         d_frame_oe;
	wire         d_dout;
	wire         d_dout_oe;
	wire         d_addr;
	wire         d_addr_oe;
	wire         play_full;
	wire         status;
	wire [15:0]  play;
	wire [15:0]  ctrl [4];
	wire         frame_bus = d_frame_oe ? d_frame : h_frame;
	wire         data_bus  = d_dout_oe ? d_dout : h_data;
	wire         addr_bus  = d_addr_oe ? d_addr : h_addr;
	wire         din       = mode_cls ? data_bus : h_data;

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	cspt_serial_port cspt_serial_port_inst (
		.i_clock                  (clock),
		.i_reset_n                (reset_n),
		.i_serial_bit_clock       (bclk),
		.i_bus_frame_line         (frame_bus),
		.o_bus_frame_line         (d_frame),
		.o_bus_frame_line_oe      (d_frame_oe),
		.i_serial_data_in         (din),
		.o_serial_data_out        (d_dout),
		.o_serial_data_out_oe     (d_dout_oe),
		.i_serial_address_line    (addr_bus),
		.o_serial_address_line    (d_addr),
		.o_serial_address_line_oe (d_addr_oe),
		.i_slot_select_pin        (slot_sel),
		.i_mode_class_pin         (mode_cls),
		.i_sample_tick            (tick),
		.i_capture_word           (cap),
		.o_playback_word          (play),
		.o_playback_full          (play_full),
		.o_status_flag            (status),
		.o_ctrl_write             (),
		.o_ctrl_reg0              (ctrl[0]),
		.o_ctrl_reg1              (ctrl[1]),
		.o_ctrl_reg2              (ctrl[2]),
		.o_ctrl_reg3              (ctrl[3])
	);

	cspt_host_model host (
		.o_serial_bit_clock    (bclk),
		.o_bus_frame_line      (h_frame),
		.o_serial_data_in      (h_data),
		.o_serial_address_line (h_addr),
		.i_data_bus            (data_bus),
		.i_address_bus         (addr_bus),
		.i_dev_oe              (d_dout_oe)
	);

	// ======================================================================
	// helpers
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, seen);
			err_count++;
		end
	endtask : check

	task automatic sample(input logic [15:0] w);
		@(posedge clock);
		tick <= 1'b1;
		cap  <= w;
		@(posedge clock);
		tick <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
	endtask : sample

	task automatic xfer(input int n);
		host.frame_xfer(n, tx, ad, rx, rxa, nb);
		repeat (8) @(posedge clock);
		#1;
	endtask : xfer

	task automatic wait_frame(input logic lvl, output int cyc);
		cyc = 0;
		while (frame_bus !== lvl && cyc < 400) begin
			@(negedge clock);
			cyc++;
		end
	endtask : wait_frame

	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test

	initial begin
		#200000;
		err_count++;
		finish_test();
	end

	// ======================================================================
	// tests
	initial begin
		reset_n    = 1'b0;
		slot_sel   = 1'b0;
		mode_cls   = 1'b0;
		tick       = 1'b0;
		cap        = 16'h0000;
		err_count  = 0;
		n_compared = 0;
		for (int s = 0; s < 8; s++) begin
			tx[s] = 16'h0f00 + 16'(s);
			ad[s] = 16'hffff;
		end
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		repeat (20) @(posedge clock);
		#1;
		check("ctrl0 reset", ctrl[0], `CSPT_CTRL0_RESET);
		check("ctrl1 reset", ctrl[1], `CSPT_CTRL1_RESET);
		check("ctrl2 reset", ctrl[2], `CSPT_CTRL2_RESET);
		check("ctrl3 reset", ctrl[3], `CSPT_CTRL3_RESET);
		$display("test reset done");

		sample(16'ha5c3);
		check("status set", 16'(status), 16'h0001);
		tx[0] = 16'h1234;
		ad[0] = 16'h7fff;
		xfer(1);
		check("capture out", rx[0], 16'ha5c3);
		check("playback", play, 16'h1234);
		check("playback full", 16'(play_full), 16'h0001);
		check("status clear", 16'(status), 16'h0000);
		for (int k = 0; k < 4; k++) begin
			tx[0] = {2'(k), 14'h0a50 + 14'(k)};
			ad[0] = ~(16'h0001 << (14 - 4 * k));
			xfer(1);
			check("ctrl reg", ctrl[k], tx[0]);
		end
		check("playback kept", play, 16'h1234);
		sample(16'h3c5a);
		check("status on dout", 16'(d_dout), 16'h0001);
		tx[0] = 16'h0001;
		ad[0] = 16'hffff;
		xfer(1);
		check("capture out 2", rx[0], 16'h3c5a);
		check("shifter on dout", 16'(d_dout), 16'h0000);
		sample(16'h0000);
		check("shifter kept on dout", 16'(d_dout), 16'h0000);
		host.addr_pulse();
		repeat (8) @(posedge clock);
		#1;
		check("status idle", 16'(d_dout), 16'h0001);
		$display("test passive done");

		@(posedge clock);
		slot_sel <= 1'b1;
		repeat (10) @(posedge clock);
		#1;
		check("strobe driven", 16'(d_frame_oe), 16'h0001);
		wait_frame(1'b1, c1);
		wait_frame(1'b0, c1);
		wait_frame(1'b1, c1);
		wait_frame(1'b0, c2);
		check("strobe spacing", 16'(c1 + c2), 16'h00a0);
		@(posedge clock);
		slot_sel <= 1'b0;
		repeat (10) @(posedge clock);
		tx[0] = 16'h1a50;
		ad[0] = 16'hbfff;
		xfer(1);
		check("ctrl0 run last", ctrl[0], 16'h1a50);
		@(posedge clock);
		slot_sel <= 1'b1;
		repeat (40) @(posedge clock);
		wait_frame(1'b0, c1);
		check("no strobe before sample", 16'(c1), 16'h0190);
		sample(16'h7e81);
		wait_frame(1'b0, c1);
		wait_frame(1'b1, c2);
		check("strobe after sample", 16'(c1 < 30 && c2 <= 10), 16'h0001);
		repeat (20) @(posedge clock);
		#1;
		check("status after strobe", 16'(status), 16'h0000);
		$display("test active done");

		for (int sel = 0; sel < 2; sel++) begin
			@(posedge clock);
			mode_cls <= 1'b1;
			slot_sel <= 1'(sel);
			repeat (10) @(posedge clock);
			own   = sel ? 5 : 2;
			tx[0] = 16'h5a00 + 16'(sel);
			ad[0] = {8'hff, ~(sel ? 8'h40 : 8'h08)};
			tx[1] = {2'b10, 14'h0123 + 14'(sel)};
			ad[1] = {8'hff, ~(sel ? 8'h80 : 8'h10)};
			tx[7] = 16'hdead;
			ad[7] = 16'hfffe;
			for (int f = 0; f < 2; f++) begin
				if (f == 0)
					sample(16'hc3a6 + 16'(sel));
				xfer(8);
				check("tdm data", rx[own], f ? 16'h0000 : 16'hc3a6 + 16'(sel));
				check("tdm addr", rxa[own], f ? 16'hffff : {8'hff, ~(sel ? 8'h20 : 8'h04)});
				check("tdm own bits", 16'(nb), 16'h0010);
				check("tdm playback", play, tx[0]);
				check("tdm ctrl", ctrl[2], tx[1]);
			end
		end
		$display("test tdm done");
		finish_test();
	end
endmodule : cspt_serial_port_test
